// file: src/ccs_regs.sv
// Charger control and status register bank with the logic the bits steer.
// Assumes a serial-bus front end giving one-cycle read and write strobes.
`timescale 1ns/1ps

module ccs_regs (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Register access port
    input wire logic [7:0] ADDR_I,
    input wire logic WR_EN_I,
    input wire logic [7:0] WDATA_I,
    input wire logic RD_EN_I,
    output logic [7:0] RDATA_O,
    output logic RVALID_O,
    // Source detection
    output logic DETECT_START_O,
    output logic DETECT_BUSY_O,
    input wire logic DETECT_DONE_I,
    // Safety timer
    input wire logic TIMER_TICK_I,
    output logic TIMER_TICK_O,
    // Battery switch
    input wire logic BAT_SWITCH_REQ_I,
    output logic BAT_SWITCH_ON_O,
    // Faults and host interrupt
    input wire logic CHARGE_FAULT_I,
    input wire logic BATTERY_OVERVOLTAGE_FAULT_I,
    output logic HOST_INT_O,
    // Charger state
    input wire logic [1:0] SRC_TYPE_I,
    input wire logic [1:0] CHARGE_PHASE_I,
    input wire logic VIN_LIMIT_I,
    input wire logic IIN_LIMIT_I,
    input wire logic POWER_GOOD_I,
    input wire logic THERMAL_REG_I,
    input wire logic SYS_MIN_I,
    // Regulation settings
    input wire logic [12:0] CHARGE_CURRENT_MA_I,
    output logic [6:0] COMP_OFFSET_MV_O,
    output logic [6:0] THERMAL_THRESH_C_O
);

    // ======================================================================
    // Decode helpers
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    function automatic logic [6:0] thermal_reg_threshold_to_celsius(input logic [1:0] code);
        case (code)
            ccs_pkg::THERMAL_REG_THRESHOLD_60: thermal_reg_threshold_to_celsius = ccs_pkg::TEMP_60_C;
            ccs_pkg::THERMAL_REG_THRESHOLD_80: thermal_reg_threshold_to_celsius = ccs_pkg::TEMP_80_C;
            ccs_pkg::THERMAL_REG_THRESHOLD_100: thermal_reg_threshold_to_celsius = ccs_pkg::TEMP_100_C;
            default: thermal_reg_threshold_to_celsius = ccs_pkg::TEMP_120_C;
        endcase
    endfunction : thermal_reg_threshold_to_celsius

    // ======================================================================
    // Storage
    logic [7:0] comp_thermal;
    logic [7:0] misc_ctrl;
    logic [7:0] sys_status;
    ccs_pkg::ccs_det_state_type det_state;
    logic timer_phase;
    logic input_limit_active;
    logic limiting;
    logic wr_comp;
    logic wr_misc;
    logic force_set;

    assign wr_comp = WR_EN_I && hit(ADDR_I, ccs_pkg::ADDR_COMP_THERMAL);
    assign wr_misc = WR_EN_I && hit(ADDR_I, ccs_pkg::ADDR_MISC_CTRL);
    assign force_set = wr_misc && WDATA_I[ccs_pkg::FORCE_DETECT_BIT];

    // ======================================================================
    // Compensation and thermal register
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            comp_thermal <= ccs_pkg::RESET_COMP_THERMAL;
        end else if (wr_comp) begin
            comp_thermal <= WDATA_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            THERMAL_THRESH_C_O <= ccs_pkg::TEMP_120_C;
        end else begin
            THERMAL_THRESH_C_O <= thermal_reg_threshold_to_celsius(
                comp_thermal[ccs_pkg::THERMAL_REG_THRESHOLD_MSB:ccs_pkg::THERMAL_REG_THRESHOLD_LSB]);
        end
    end

    ccs_comp u_comp (
        .CLK_I(CLK_I),
        .RESET_I(RESET_I),
        .COMP_RES_I(comp_thermal[ccs_pkg::COMP_RES_MSB:ccs_pkg::COMP_RES_LSB]),
        .CLAMP_I(comp_thermal[ccs_pkg::CLAMP_MSB:ccs_pkg::CLAMP_LSB]),
        .CHARGE_CURRENT_MA_I(CHARGE_CURRENT_MA_I),
        .COMP_OFFSET_MV_O(COMP_OFFSET_MV_O)
    );

    // ======================================================================
    // Misc control register
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            misc_ctrl <= ccs_pkg::RESET_MISC_CTRL;
        end else begin
            if (wr_misc) begin
                misc_ctrl[6:0] <= WDATA_I[6:0];
            end
            if (force_set) begin
                misc_ctrl[ccs_pkg::FORCE_DETECT_BIT] <= 1'b1;
            end else if (det_state == ccs_pkg::DET_RUN && DETECT_DONE_I) begin
                misc_ctrl[ccs_pkg::FORCE_DETECT_BIT] <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Source detection sequencing
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            det_state <= ccs_pkg::DET_IDLE;
        end else begin
            case (det_state)
                ccs_pkg::DET_IDLE: begin
                    if (force_set) begin
                        det_state <= ccs_pkg::DET_RUN;
                    end
                end
                ccs_pkg::DET_RUN: begin
                    if (DETECT_DONE_I && !force_set) begin
                        det_state <= ccs_pkg::DET_IDLE;
                    end
                end
                default: begin
                    det_state <= ccs_pkg::DET_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            DETECT_START_O <= 1'b0;
        end else begin
            DETECT_START_O <= force_set && det_state == ccs_pkg::DET_IDLE;
        end
    end

    assign DETECT_BUSY_O = (det_state == ccs_pkg::DET_RUN);

    // ======================================================================
    // Safety timer rate
    assign input_limit_active = VIN_LIMIT_I || IIN_LIMIT_I;
    assign limiting = input_limit_active || THERMAL_REG_I;

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            timer_phase <= 1'b0;
        end else if (TIMER_TICK_I) begin
            timer_phase <= !timer_phase;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            TIMER_TICK_O <= 1'b0;
        end else if (misc_ctrl[ccs_pkg::HALF_RATE_BIT] && limiting) begin
            TIMER_TICK_O <= TIMER_TICK_I && timer_phase;
        end else begin
            TIMER_TICK_O <= TIMER_TICK_I;
        end
    end

    // ======================================================================
    // Battery switch
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            BAT_SWITCH_ON_O <= 1'b0;
        end else begin
            BAT_SWITCH_ON_O <= BAT_SWITCH_REQ_I
                && !misc_ctrl[ccs_pkg::BAT_SWITCH_OFF_BIT];
        end
    end

    // ======================================================================
    // Fault interrupt, registered from the enabled fault levels
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            HOST_INT_O <= 1'b0;
        end else begin
            HOST_INT_O <= (CHARGE_FAULT_I && misc_ctrl[ccs_pkg::CHG_FAULT_INT_BIT])
                || (BATTERY_OVERVOLTAGE_FAULT_I && misc_ctrl[ccs_pkg::BATTERY_OVERVOLTAGE_FAULT_INT_BIT]);
        end
    end

    // ======================================================================
    // Status capture
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            sys_status <= 8'h00;
        end else begin
            sys_status[ccs_pkg::SRC_TYPE_MSB:ccs_pkg::SRC_TYPE_LSB] <= SRC_TYPE_I;
            sys_status[ccs_pkg::PHASE_MSB:ccs_pkg::PHASE_LSB] <= CHARGE_PHASE_I;
            sys_status[ccs_pkg::INPUT_LIMIT_BIT] <= input_limit_active;
            sys_status[ccs_pkg::POWER_GOOD_BIT] <= POWER_GOOD_I;
            sys_status[ccs_pkg::THERMAL_BIT] <= THERMAL_REG_I;
            sys_status[ccs_pkg::SYS_MIN_BIT] <= SYS_MIN_I;
        end
    end

    // ======================================================================
    // Read path
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            RDATA_O <= 8'h00;
            RVALID_O <= 1'b0;
        end else begin
            RVALID_O <= RD_EN_I;
            if (RD_EN_I) begin
                if (hit(ADDR_I, ccs_pkg::ADDR_COMP_THERMAL)) begin
                    RDATA_O <= comp_thermal;
                end else if (hit(ADDR_I, ccs_pkg::ADDR_MISC_CTRL)) begin
                    RDATA_O <= misc_ctrl;
                end else if (hit(ADDR_I, ccs_pkg::ADDR_SYS_STATUS)) begin
                    RDATA_O <= sys_status;
                end else begin
                    RDATA_O <= 8'h00;
                end
            end
        end
    end

endmodule : ccs_regs

// file: src/ccs_pkg.sv
// Constants, field layouts and reset values for the charger control and status registers.
// Assumes a serial-bus front end that hands over byte-wide register reads and writes.

// ==========================================================================
// Package
package ccs_pkg;

    // ======================================================================
    // Register offsets
    localparam logic [7:0] ADDR_COMP_THERMAL = 8'h06;
    localparam logic [7:0] ADDR_MISC_CTRL = 8'h07;
    localparam logic [7:0] ADDR_SYS_STATUS = 8'h08;

    // ======================================================================
    // Reset values
    localparam logic [7:0] RESET_COMP_THERMAL = 8'h03;
    localparam logic [7:0] RESET_MISC_CTRL = 8'h4B;

    // ======================================================================
    // Compensation and thermal register fields
    localparam int COMP_RES_MSB = 7;
    localparam int COMP_RES_LSB = 5;
    localparam int CLAMP_MSB = 4;
    localparam int CLAMP_LSB = 2;
    localparam int THERMAL_REG_THRESHOLD_MSB = 1;
    localparam int THERMAL_REG_THRESHOLD_LSB = 0;
    localparam logic [4:0] COMP_RES_STEP_MOHM = 5'h0A;
    localparam logic [4:0] CLAMP_STEP_MV = 5'h10;
    localparam logic [9:0] MV_PER_MA_MOHM = 10'h3E8;

    // ======================================================================
    // Thermal thresholds in degrees Celsius
    localparam logic [1:0] THERMAL_REG_THRESHOLD_60 = 2'h0;
    localparam logic [1:0] THERMAL_REG_THRESHOLD_80 = 2'h1;
    localparam logic [1:0] THERMAL_REG_THRESHOLD_100 = 2'h2;
    localparam logic [1:0] THERMAL_REG_THRESHOLD_120 = 2'h3;
    localparam logic [6:0] TEMP_60_C = 7'h3C;
    localparam logic [6:0] TEMP_80_C = 7'h50;
    localparam logic [6:0] TEMP_100_C = 7'h64;
    localparam logic [6:0] TEMP_120_C = 7'h78;

    // ======================================================================
    // Misc control register fields
    localparam int FORCE_DETECT_BIT = 7;
    localparam int HALF_RATE_BIT = 6;
    localparam int BAT_SWITCH_OFF_BIT = 5;
    localparam int CHG_FAULT_INT_BIT = 1;
    localparam int BATTERY_OVERVOLTAGE_FAULT_INT_BIT = 0;

    // ======================================================================
    // Status register fields
    localparam int SRC_TYPE_MSB = 7;
    localparam int SRC_TYPE_LSB = 6;
    localparam int PHASE_MSB = 5;
    localparam int PHASE_LSB = 4;
    localparam int INPUT_LIMIT_BIT = 3;
    localparam int POWER_GOOD_BIT = 2;
    localparam int THERMAL_BIT = 1;
    localparam int SYS_MIN_BIT = 0;

    // ======================================================================
    // Source type and charge phase codes
    localparam logic [1:0] SRC_UNKNOWN = 2'h0;
    localparam logic [1:0] SRC_USB_HOST = 2'h1;
    localparam logic [1:0] SRC_ADAPTER = 2'h2;
    localparam logic [1:0] SRC_OTG = 2'h3;
    localparam logic [1:0] PHASE_IDLE = 2'h0;
    localparam logic [1:0] PHASE_PRECHARGE = 2'h1;
    localparam logic [1:0] PHASE_FAST = 2'h2;
    localparam logic [1:0] PHASE_DONE = 2'h3;

    // ======================================================================
    // Source detection states
    typedef enum logic [1:0] {
        DET_IDLE = 2'b01,
        DET_RUN = 2'b10
    } ccs_det_state_type;

endpackage : ccs_pkg

// file: src/ccs_comp.sv
// Battery-path compensation offset: charge current times resistance, clamped.
// Assumes charge current in mA, synchronous to the charger clock.
`timescale 1ns/1ps

module ccs_comp (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Settings
    input wire logic [2:0] COMP_RES_I,
    input wire logic [2:0] CLAMP_I,
    // Measurement
    input wire logic [12:0] CHARGE_CURRENT_MA_I,
    // Result
    output logic [6:0] COMP_OFFSET_MV_O
);

    // ======================================================================
    // Offset computation
    logic [6:0] res_mohm;
    logic [6:0] clamp_mv;
    logic [19:0] product;
    logic [19:0] raw_mv;
    logic [6:0] next_offset;

    always_comb begin
        res_mohm = 7'(COMP_RES_I) * 7'(ccs_pkg::COMP_RES_STEP_MOHM);
        clamp_mv = 7'(CLAMP_I) * 7'(ccs_pkg::CLAMP_STEP_MV);
        product = 20'(CHARGE_CURRENT_MA_I) * 20'(res_mohm);
        raw_mv = 20'(product / ccs_pkg::MV_PER_MA_MOHM);
        if (raw_mv > 20'(clamp_mv)) begin
            next_offset = clamp_mv;
        end else begin
            next_offset = raw_mv[6:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            COMP_OFFSET_MV_O <= 7'h00;
        end else begin
            COMP_OFFSET_MV_O <= next_offset;
        end
    end

endmodule : ccs_comp

// file: verif/ccs_regs_assertions.sv
// Concurrent checks on the charger register bank ports.
// Assumes it is bound to every ccs_regs instance.
`timescale 1ns/1ps
// ==========================================================================
// Checker
module ccs_regs_assertions (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic WR_EN_I,
    input wire logic [7:0] WDATA_I,
    input wire logic RD_EN_I,
    input wire logic [7:0] RDATA_O,
    input wire logic RVALID_O,
    // Controls
    input wire logic DETECT_START_O,
    input wire logic DETECT_BUSY_O,
    input wire logic DETECT_DONE_I,
    input wire logic TIMER_TICK_I,
    input wire logic TIMER_TICK_O,
    input wire logic BAT_SWITCH_REQ_I,
    input wire logic BAT_SWITCH_ON_O,
    input wire logic CHARGE_FAULT_I,
    input wire logic BATTERY_OVERVOLTAGE_FAULT_I,
    input wire logic HOST_INT_O,
    input wire logic [6:0] THERMAL_THRESH_C_O,
    // Status
    input wire logic [1:0] SRC_TYPE_I,
    input wire logic [1:0] CHARGE_PHASE_I,
    input wire logic VIN_LIMIT_I,
    input wire logic IIN_LIMIT_I,
    input wire logic POWER_GOOD_I,
    input wire logic THERMAL_REG_I,
    input wire logic SYS_MIN_I
);
    logic [1:0] last_wd;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    always_ff @(posedge CLK_I) begin
        last_wd <= WDATA_I[1:0];
    end
    AST_RVALID: assert property (RVALID_O == $past(RD_EN_I))
        else $error("read valid not one cycle after read strobe");
    AST_STATUS: assert property (RD_EN_I && ADDR_I == 8'h08 |=>
        RDATA_O == {$past(SRC_TYPE_I, 2), $past(CHARGE_PHASE_I, 2),
        $past(VIN_LIMIT_I, 2) | $past(IIN_LIMIT_I, 2), $past(POWER_GOOD_I, 2),
        $past(THERMAL_REG_I, 2), $past(SYS_MIN_I, 2)})
        else $error("status word does not match inputs");
    AST_TICK: assert property (TIMER_TICK_I && !VIN_LIMIT_I && !IIN_LIMIT_I
        && !THERMAL_REG_I |=> TIMER_TICK_O) else $error("tick lost without limiting");
    AST_TICK_SRC: assert property (TIMER_TICK_O |-> $past(TIMER_TICK_I))
        else $error("tick out without tick in");
    AST_SWITCH: assert property (BAT_SWITCH_ON_O |-> $past(BAT_SWITCH_REQ_I))
        else $error("switch on without request");
    AST_INT: assert property (HOST_INT_O |-> $past(CHARGE_FAULT_I) || $past(BATTERY_OVERVOLTAGE_FAULT_I))
        else $error("interrupt without fault");
    AST_START: assert property (DETECT_START_O |-> $past(WR_EN_I) &&
        $past(ADDR_I) == 8'h07 && !$past(DETECT_BUSY_O)) else $error("bad detect start");
    AST_DONE: assert property (DETECT_BUSY_O && DETECT_DONE_I && !WR_EN_I |=>
        !DETECT_BUSY_O) else $error("detection not ended by done");
    AST_THRESH: assert property (WR_EN_I && ADDR_I == 8'h06 |=> ##1
        THERMAL_THRESH_C_O == 7'h3C + 7'h14 * $past(last_wd)) else $error("bad threshold");
    C_DETECT: cover property (DETECT_START_O);
    C_INT: cover property (HOST_INT_O);
    C_STATUS: cover property (RD_EN_I && ADDR_I == 8'h08);
endmodule : ccs_regs_assertions

bind ccs_regs ccs_regs_assertions chk (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WR_EN_I(WR_EN_I),
    .WDATA_I(WDATA_I), .RD_EN_I(RD_EN_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
    .DETECT_START_O(DETECT_START_O), .DETECT_BUSY_O(DETECT_BUSY_O),
    .DETECT_DONE_I(DETECT_DONE_I), .TIMER_TICK_I(TIMER_TICK_I), .TIMER_TICK_O(TIMER_TICK_O),
    .BAT_SWITCH_REQ_I(BAT_SWITCH_REQ_I), .BAT_SWITCH_ON_O(BAT_SWITCH_ON_O),
    .CHARGE_FAULT_I(CHARGE_FAULT_I), .BATTERY_OVERVOLTAGE_FAULT_I(BATTERY_OVERVOLTAGE_FAULT_I), .HOST_INT_O(HOST_INT_O),
    .THERMAL_THRESH_C_O(THERMAL_THRESH_C_O), .SRC_TYPE_I(SRC_TYPE_I),
    .CHARGE_PHASE_I(CHARGE_PHASE_I), .VIN_LIMIT_I(VIN_LIMIT_I), .IIN_LIMIT_I(IIN_LIMIT_I),
    .POWER_GOOD_I(POWER_GOOD_I), .THERMAL_REG_I(THERMAL_REG_I), .SYS_MIN_I(SYS_MIN_I)
);

// file: verif/ccs_host.sv
// Host model driving the byte-wide register strobe port.
// Assumes one-cycle strobes and read data one cycle after the read edge.
`timescale 1ns/1ps
// ==========================================================================
// Host
module ccs_host (
    // Clock
    input wire logic clk_i,
    // Register port
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic wr_en_o,
    output logic [7:0] wdata_o,
    output logic rd_en_o
);
    initial begin
        addr_o = 8'h00;
        wr_en_o = 1'b0;
        wdata_o = 8'h00;
        rd_en_o = 1'b0;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) begin addr_o <= a; wdata_o <= d; wr_en_o <= 1'b1; end
        @(posedge clk_i) wr_en_o <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i) begin addr_o <= a; rd_en_o <= 1'b1; end
        @(posedge clk_i) rd_en_o <= 1'b0;
        @(posedge clk_i) d = rdata_i;
    endtask : rd
    // Clears the masked bits, ORs in the new value unmasked and keeps the rest as read.
    task rmw(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        logic [7:0] t;
        rd(a, t);
        wr(a, (t & ~m) | v);
    endtask : rmw
endmodule : ccs_host

// file: verif/charger_control_status_regs_test.sv
// Self-checking bench for the charger register bank.
// Assumes ccs_regs, its checker and the host model are compiled before it.
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
// ==========================================================================
// Bench
module charger_control_status_regs_test;
    logic clk, rst, wr, rd, done, tick, req, cf, bf, vin, iin, pg, th, sm;
    logic rv, st, busy, tko, son, hint;
    logic [7:0] addr, wdata, rdata, d;
    logic [1:0] src, ph;
    logic [12:0] cur;
    logic [6:0] off, thr;
    int bad_count, tests_run, n_tick, n_int, n_start, b;
    ccs_regs uut (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WR_EN_I(wr), .WDATA_I(wdata),
        .RD_EN_I(rd), .RDATA_O(rdata), .RVALID_O(rv), .DETECT_START_O(st),
        .DETECT_BUSY_O(busy), .DETECT_DONE_I(done), .TIMER_TICK_I(tick), .TIMER_TICK_O(tko),
        .BAT_SWITCH_REQ_I(req), .BAT_SWITCH_ON_O(son), .CHARGE_FAULT_I(cf), .BATTERY_OVERVOLTAGE_FAULT_I(bf),
        .HOST_INT_O(hint), .SRC_TYPE_I(src), .CHARGE_PHASE_I(ph), .VIN_LIMIT_I(vin),
        .IIN_LIMIT_I(iin), .POWER_GOOD_I(pg), .THERMAL_REG_I(th), .SYS_MIN_I(sm),
        .CHARGE_CURRENT_MA_I(cur), .COMP_OFFSET_MV_O(off), .THERMAL_THRESH_C_O(thr));
    ccs_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_en_o(wr),
        .wdata_o(wdata), .rd_en_o(rd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        n_tick += (tko === 1'b1);
        n_int += (hint === 1'b1);
        n_start += (st === 1'b1);
    end
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        `CHK("rdata", e, d)
    endtask : rchk
    task t_reset;
        rchk(8'h06, 8'h03);
        rchk(8'h07, 8'h4B);
        rchk(8'h0F, 8'h00);
        `CHK("thr", 7'h78, thr)
    endtask : t_reset
    task t_thr;
        for (int k = 0; k < 4; k++) begin
            host.wr(8'h06, k[7:0]);
            wt(2);
            `CHK("thr", 7'h3C + 7'h14 * k[6:0], thr)
        end
    endtask : t_thr
    task t_comp;
        logic [7:0] w [5] = '{8'hFF, 8'hFF, 8'hE7, 8'h3C, 8'hE3};
        int ci [5] = '{1000, 8191, 2000, 8191, 4000};
        int e;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk) cur <= ci[k][12:0];
            host.wr(8'h06, w[k]);
            wt(3);
            e = ci[k] * w[k][7:5] * 10 / 1000;
            if (e > w[k][4:2] * 16) e = w[k][4:2] * 16;
            `CHK("offset", e[6:0], off)
            rchk(8'h06, w[k]);
        end
    endtask : t_comp
    task t_stat;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) begin src <= i[1:0]; ph <= 2'(3 - i); vin <= i == 1; iin <= i == 2;
                pg <= i[0]; th <= i[1]; sm <= i == 3; end
            host.wr(8'h08, 8'hFF);
            rchk(8'h08, {i[1:0], 2'(3 - i), i == 1 || i == 2, i[0], i[1], i == 3});
        end
        @(posedge clk) th <= 1'b0;
    endtask : t_stat
    task t_misc;
        host.wr(8'h07, 8'h00);
        rchk(8'h07, 8'h00);
        host.wr(8'h07, 8'h1C);
        rchk(8'h07, 8'h1C);
        host.wr(8'h07, 8'h4B);
        host.rmw(8'h07, 8'h20, 8'h20);
        wt(2);
        `CHK("switch", 1'b0, son)
        host.rmw(8'h07, 8'h20, 8'h00);
        wt(2);
        `CHK("switch", 1'b1, son)
    endtask : t_misc
    task t_int;
        for (int m = 0; m < 4; m++) begin
            host.wr(8'h07, 8'h48 | m[7:0]);
            for (int f = 0; f < 2; f++) begin
                b = n_int;
                @(posedge clk) begin cf <= f == 0; bf <= f == 1; end
                @(posedge clk) begin cf <= 1'b0; bf <= 1'b0; end
                wt(2);
                `CHK("interrupts", int'(m[1 - f]), n_int - b)
            end
        end
    endtask : t_int
    task t_tmr;
        for (int h = 0; h < 3; h++) begin
            host.wr(8'h07, h == 0 ? 8'h0B : 8'h4B);
            @(posedge clk) th <= h < 2;
            b = n_tick;
            repeat (4) begin
                @(posedge clk) tick <= 1'b1;
                @(posedge clk) tick <= 1'b0;
            end
            wt(2);
            `CHK("ticks", h == 1 ? 2 : 4, n_tick - b)
        end
        @(posedge clk) th <= 1'b0;
    endtask : t_tmr
    task t_det;
        b = n_start;
        host.wr(8'h07, 8'hCB);
        wt(1);
        `CHK("busy", 1'b1, busy)
        host.wr(8'h07, 8'h4B);
        rchk(8'h07, 8'hCB);
        fork
            host.wr(8'h07, 8'hCB);
            begin
                @(posedge clk) done <= 1'b1;
                @(posedge clk) done <= 1'b0;
            end
        join
        wt(1);
        `CHK("busy", 1'b1, busy)
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        wt(2);
        `CHK("busy", 1'b0, busy)
        rchk(8'h07, 8'h4B);
        `CHK("starts", 1, n_start - b)
    endtask : t_det
    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_of_test;
    end
    initial begin
        {rst, done, tick, req, cf, bf, vin, iin, pg, th, sm} = 11'h481;
        src = 2'h0;
        ph = 2'h0;
        cur = 13'h0000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_thr;
        t_comp;
        t_stat;
        t_misc;
        t_int;
        t_tmr;
        t_det;
        end_of_test;
    end
endmodule : charger_control_status_regs_test
